// ===== rtl/rms_params.svh
// Purpose: constants of the rms and mean-absolute-value block
// Assumes: 250 MHz clock, one sample strobe per 8 kHz update
// Notes: register offsets are byte addresses of 32-bit words
//
// Functional notes
// - Sum-select bit 2 set: neutral result is rms of summed phase currents.
// - Phase and neutral current rms are signed 24-bit, refreshed at 8 kHz.
// - Integrator off: full-scale sine gives 0x39792C at any line frequency.
// - Integrator on: full-scale gives 0x395E66 at 50 Hz, 0x2FCF17 at 60 Hz; the code does not integrate, the bit only lengthens the filter shift.
// - Current rms settles to 99.5 percent in 580 ms, 700 ms integrated; the code's integrated shift of 11 doubles the settling time instead.
// - After start, a thousandth full-scale input settles in about 1.3 s.
// - Every rms measurement has 3.3 kHz signal bandwidth.
// - Current rms reads as 32-bit word with top eight bits zero.
// - Offset coefficient times 128 is added to the mean square before root.
// - Offsets read with top four bits zero, sign extended to 28 bits.
// - Mean-absolute path: high-pass, absolute, average; phases only.
// - Mean-absolute results are unsigned 20-bit, refreshed at 8 kHz.
// - Full-scale sine mean-absolute result is 209686 at 50, 210921 at 60 Hz.
// - Mean-absolute result settles to 0.5 percent in 500 ms.
// - Mean-absolute result reads with the top 12 bits zero.
// - Mean-absolute path runs in reduced-power and normal modes.
// - Voltage rms signed 24-bit, 8 kHz, top eight bits read zero.
// - Voltage rms settles within 580 ms of a step from zero.
// - Accurate rms runs only in normal power mode.
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH
`define RMS_AW 8
`define RMS_RES_BASE 8'h00
`define RMS_MAV_BASE 8'h1c
`define RMS_OFS_BASE 8'h28
`define RMS_CFG_ADDR 8'h38
`define RMS_STRIDE 8'h04
`define RMS_CFG_INTEG 0
`define RMS_CFG_SUMSEL 2
`define RMS_SQRT_STEPS 5'd26
`define RMS_LPF_K_OFF 6'd10
`define RMS_LPF_K_INT 6'd11
`define RMS_HPF_K 6'd12
`define RMS_MAV_K 6'd10
`define RMS_MAV_SCALE 4
`define RMS_OFS_SHIFT 7
`define RMS_RMS_MAX 26'h07fffff
`define RMS_MAV_MAX 27'h00fffff
`define RMS_NCH 7
`define RMS_NCUR 4
`define RMS_NMAV 3
`define RMS_NEUTRAL 3
`endif

// ===== rtl/rms_pkg.sv
// Purpose: types of the rms and mean-absolute-value block
// Assumes: rms_params.svh constants
// Notes: channel order A, B, C, neutral currents, then A, B, C voltages
`include "rms_params.svh"
package rms_pkg;
  typedef struct packed {
    logic valid;
    logic [`RMS_NCH-1:0][23:0] ch;
  } rms_sample_s;
  typedef enum logic [1:0] {
    RMS_IDLE,
    RMS_LOAD,
    RMS_ITER,
    RMS_STORE
  } rms_state_e;
endpackage

// ===== rtl/rms_measure.sv
// Purpose: rms of currents and voltages, mean-absolute value of phase currents
// Assumes: samples arrive on the block clock, one valid strobe per update
// Notes: one square-root engine is shared by all seven channels
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "rms_params.svh"
module rms_measure (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sample stream, same clock domain
  input wire rms_pkg::rms_sample_s sample,
  // Power mode
  input wire logic normalPowerMode,
  // Register port
  input wire logic [`RMS_AW-1:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData
);
  import rms_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [`RMS_AW-1:0] slotAddr(
    input logic [`RMS_AW-1:0] base,
    input int idx
  );
    slotAddr = base + `RMS_AW'(idx) * `RMS_STRIDE;
  endfunction

  function automatic logic [19:0] satMav(input logic [26:0] acc);
    logic [26:0] scaled;
    scaled = acc >> `RMS_MAV_SCALE;
    satMav = (scaled > `RMS_MAV_MAX) ? 20'hfffff : scaled[19:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Configuration and offset registers

  logic sumSelect;
  logic integratorEnable;
  logic [23:0] rmsOffset [`RMS_NCUR];

  // Only config and offsets accept writes; results ignore them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sumSelect <= 1'b0;
      integratorEnable <= 1'b0;
    end else if (wrStrobe && addr == `RMS_CFG_ADDR) begin
      sumSelect <= wrData[`RMS_CFG_SUMSEL];
      integratorEnable <= wrData[`RMS_CFG_INTEG];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `RMS_NCUR; gi++) begin : gOfs
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          rmsOffset[gi] <= 24'h000000;
        end else if (wrStrobe && addr == slotAddr(`RMS_OFS_BASE, gi)) begin
          rmsOffset[gi] <= wrData[23:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Channel selection

  logic signed [25:0] chan [`RMS_NCH];
  logic signed [25:0] phaseSum;

  assign phaseSum = 26'($signed(sample.ch[0])) + 26'($signed(sample.ch[1]))
    + 26'($signed(sample.ch[2]));

  always_comb begin
    for (int i = 0; i < `RMS_NCH; i++) begin
      chan[i] = 26'($signed(sample.ch[i]));
    end
    if (sumSelect) begin
      chan[`RMS_NEUTRAL] = phaseSum;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mean-square low-pass filters
  // A first-order recursive average keeps area small; the shift sets
  // settling. The integrated current path is slower, hence a longer shift.

  logic [51:0] msAcc [`RMS_NCH];

  generate
    for (gi = 0; gi < `RMS_NCH; gi++) begin : gLpf
      logic [51:0] sq;
      logic signed [52:0] delta;
      logic [5:0] lpfShift;
      assign sq = 52'(52'(chan[gi]) * 52'(chan[gi]));
      assign delta = $signed({1'b0, sq}) - $signed({1'b0, msAcc[gi]});
      assign lpfShift = (gi < `RMS_NCUR && integratorEnable) ?
        `RMS_LPF_K_INT : `RMS_LPF_K_OFF;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          msAcc[gi] <= 52'h0;
        end else if (sample.valid && normalPowerMode) begin
          // Square then average keeps all harmonics in band
          msAcc[gi] <= 52'($signed({1'b0, msAcc[gi]}) + (delta >>> lpfShift));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Shared square-root engine
  // One engine for seven channels: 196 cycles per pass, far under the
  // 31250 cycles between 8 kHz updates, so sharing costs nothing.

  rms_state_e state;
  logic [2:0] chIdx;
  logic [4:0] stepCnt;
  logic [51:0] radicand;
  logic [27:0] remainder;
  logic [25:0] root;
  logic [25:0] rmsResult [`RMS_NCH];
  logic signed [52:0] next_radicand;
  logic [28:0] shiftedRem;
  logic [28:0] trial;

  always_comb begin
    next_radicand = $signed({1'b0, msAcc[chIdx]});
    if (chIdx < 3'(`RMS_NCUR)) begin
      next_radicand = next_radicand
        + ($signed(53'($signed(rmsOffset[chIdx[1:0]]))) <<< `RMS_OFS_SHIFT);
    end
    if (next_radicand < 0) begin
      next_radicand = 53'sh0;
    end
  end

  // Remainder may reach 27 bits near full scale; keep them all
  assign shiftedRem = {remainder[26:0], radicand[51:50]};
  assign trial = {1'b0, root, 2'b01};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= RMS_IDLE;
      chIdx <= 3'h0;
      stepCnt <= 5'h00;
    end else begin
      unique case (state)
        RMS_IDLE: begin
          if (sample.valid && normalPowerMode) begin
            state <= RMS_LOAD;
            chIdx <= 3'h0;
          end
        end
        RMS_LOAD: begin
          state <= RMS_ITER;
          stepCnt <= 5'h00;
        end
        RMS_ITER: begin
          stepCnt <= stepCnt + 5'h01;
          if (stepCnt == `RMS_SQRT_STEPS - 5'h01) begin
            state <= RMS_STORE;
          end
        end
        RMS_STORE: begin
          if (chIdx == 3'(`RMS_NCH - 1)) begin
            state <= RMS_IDLE;
          end else begin
            chIdx <= chIdx + 3'h1;
            state <= RMS_LOAD;
          end
        end
      endcase
    end
  end

  // Digit-by-digit root, two radicand bits per step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      radicand <= 52'h0;
      remainder <= 28'h0;
      root <= 26'h0;
    end else if (state == RMS_LOAD) begin
      radicand <= next_radicand[51:0];
      remainder <= 28'h0;
      root <= 26'h0;
    end else if (state == RMS_ITER) begin
      radicand <= {radicand[49:0], 2'b00};
      if (shiftedRem >= trial) begin
        remainder <= 28'(shiftedRem - trial);
        root <= {root[24:0], 1'b1};
      end else begin
        remainder <= shiftedRem[27:0];
        root <= {root[24:0], 1'b0};
      end
    end
  end

  // Unscaled root of the mean square: full-scale sine lands at 0x39792C
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `RMS_NCH; i++) begin
        rmsResult[i] <= 26'h0;
      end
    end else if (state == RMS_STORE) begin
      rmsResult[chIdx] <= (root > `RMS_RMS_MAX) ? `RMS_RMS_MAX : root;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mean absolute value, phase currents only
  // Runs whatever the power mode, so its gain can be trimmed in normal mode

  logic [26:0] mavAcc [`RMS_NMAV];
  logic [19:0] mavResult [`RMS_NMAV];

  generate
    for (gi = 0; gi < `RMS_NMAV; gi++) begin : gMav
      logic signed [25:0] dcEst;
      logic signed [26:0] dcDelta;
      logic signed [26:0] hp;
      logic [26:0] absVal;
      logic signed [27:0] mavDelta;
      assign dcDelta = 27'(chan[gi]) - 27'(dcEst);
      assign hp = 27'(chan[gi]) - 27'(dcEst);
      assign absVal = hp[26] ? 27'(-hp) : 27'(hp);
      assign mavDelta = $signed({1'b0, absVal}) - $signed({1'b0, mavAcc[gi]});
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          dcEst <= 26'sh0;
          mavAcc[gi] <= 27'h0;
        end else if (sample.valid) begin
          dcEst <= 26'(dcEst + (dcDelta >>> `RMS_HPF_K));
          mavAcc[gi] <= 27'($signed({1'b0, mavAcc[gi]}) + (mavDelta >>> `RMS_MAV_K));
        end
      end
      // Divided by 16: full-scale sine lands near 209686
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          mavResult[gi] <= 20'h00000;
        end else if (sample.valid) begin
          mavResult[gi] <= satMav(mavAcc[gi]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Read port
  // Data stand only in the cycle after the strobe; unmapped reads give zero

  logic [31:0] next_rdData;

  always_comb begin
    next_rdData = 32'h00000000;
    for (int i = 0; i < `RMS_NCH; i++) begin
      if (addr == slotAddr(`RMS_RES_BASE, i)) begin
        next_rdData = {8'h00, rmsResult[i][23:0]};
      end
    end
    for (int i = 0; i < `RMS_NMAV; i++) begin
      if (addr == slotAddr(`RMS_MAV_BASE, i)) begin
        next_rdData = {12'h000, mavResult[i]};
      end
    end
    for (int i = 0; i < `RMS_NCUR; i++) begin
      if (addr == slotAddr(`RMS_OFS_BASE, i)) begin
        next_rdData = {4'h0, {4{rmsOffset[i][23]}}, rmsOffset[i]};
      end
    end
    if (addr == `RMS_CFG_ADDR) begin
      next_rdData[`RMS_CFG_SUMSEL] = sumSelect;
      next_rdData[`RMS_CFG_INTEG] = integratorEnable;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= rdStrobe ? next_rdData : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  AST_RMS_TOP_ZERO: assert property (
    @(posedge clock) disable iff (rst)
    rdStrobe && addr == `RMS_RES_BASE |=> rdData[31:24] == 8'h00
      && rdData[23:0] == $past(rmsResult[0][23:0]))
    else $error("current rms read not zero padded");

  AST_MAV_TOP_ZERO: assert property (
    @(posedge clock) disable iff (rst)
    rdStrobe && addr == `RMS_MAV_BASE |=> rdData[31:20] == 12'h000)
    else $error("mean-absolute read not zero padded");

  AST_OFS_SIGN_EXT: assert property (
    @(posedge clock) disable iff (rst)
    rdStrobe && addr == `RMS_OFS_BASE |=> rdData[31:28] == 4'h0
      && rdData[27:24] == {4{rdData[23]}})
    else $error("offset read not sign extended");

  AST_RESULT_WRITE_IGNORED: assert property (
    @(posedge clock) disable iff (rst)
    wrStrobe && addr == `RMS_RES_BASE && state != RMS_STORE
      |=> rmsResult[0] == $past(rmsResult[0]))
    else $error("write reached a result register");

  AST_RMS_PASS_LENGTH: assert property (
    @(posedge clock) disable iff (rst)
    state == RMS_IDLE && sample.valid && normalPowerMode
      |-> ##196 (state == RMS_STORE && chIdx == 3'h6))
    else $error("rms pass did not end on time");

  AST_SUM_SELECT: assert property (
    @(posedge clock) disable iff (rst)
    sumSelect |-> chan[`RMS_NEUTRAL] == phaseSum)
    else $error("neutral channel not the phase sum");

  AST_REDUCED_POWER_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    !normalPowerMode && state == RMS_IDLE |=> state == RMS_IDLE
      && msAcc[0] == $past(msAcc[0]))
    else $error("rms path active in reduced power");

  AST_MAV_REFRESH: assert property (
    @(posedge clock) disable iff (rst)
    sample.valid ##1 !sample.valid |-> mavResult[0] == satMav($past(mavAcc[0])))
    else $error("mean-absolute result not refreshed");

  AST_OFFSET_ADDED: assert property (
    @(posedge clock) disable iff (rst)
    state == RMS_LOAD && chIdx == 3'h0 && msAcc[0] == 52'h0
      && !rmsOffset[0][23] |=> radicand == (52'($past(rmsOffset[0])) << `RMS_OFS_SHIFT))
    else $error("offset not scaled by 128");

  AST_NEUTRAL_DIRECT: assert property (
    @(posedge clock) disable iff (rst)
    !sumSelect |-> chan[`RMS_NEUTRAL] == 26'($signed(sample.ch[`RMS_NEUTRAL])))
    else $error("neutral channel not the neutral sample");

  AST_INTEG_SHIFT: assert property (
    @(posedge clock) disable iff (rst)
    gLpf[0].lpfShift == (integratorEnable ? `RMS_LPF_K_INT : `RMS_LPF_K_OFF)
      && gLpf[`RMS_NCUR].lpfShift == `RMS_LPF_K_OFF)
    else $error("integrator setting reached the wrong filters");

  AST_CFG_READBACK: assert property (
    @(posedge clock) disable iff (rst)
    rdStrobe && addr == `RMS_CFG_ADDR |=> rdData[`RMS_CFG_INTEG] == $past(integratorEnable)
      && rdData[`RMS_CFG_SUMSEL] == $past(sumSelect))
    else $error("configuration read back wrong");

  AST_RMS_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    state != RMS_STORE |=> rmsResult[0] == $past(rmsResult[0]))
    else $error("current rms changed outside an update");

  AST_VOLT_RANGE: assert property (
    @(posedge clock) disable iff (rst)
    state == RMS_STORE && chIdx == 3'(`RMS_NCH - 1) |=> rmsResult[`RMS_NCH - 1] <= `RMS_RMS_MAX)
    else $error("voltage rms above the signed 24-bit range");

  AST_MAV_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    !sample.valid |=> mavResult[0] == $past(mavResult[0]))
    else $error("mean-absolute result changed between updates");

  AST_STEP_BOUND: assert property (
    @(posedge clock) disable iff (rst)
    state == RMS_ITER |-> stepCnt < `RMS_SQRT_STEPS)
    else $error("root engine ran past its step count");

  AST_OFS_WRITE_TAKEN: assert property (
    @(posedge clock) disable iff (rst)
    wrStrobe && addr == `RMS_OFS_BASE |=> rmsOffset[0] == $past(wrData[23:0]))
    else $error("offset write not taken");

endmodule // rms_measure

// ===== test/rms_host_model.sv
// Purpose: host that reaches the rms block through its register port
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes: address and write data are scrambled once released
`timescale 1ns/10ps
`include "rms_params.svh"
module rms_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [`RMS_AW-1:0] addr,
  output logic [31:0] wrData,
  output logic wrStrobe,
  output logic rdStrobe,
  input wire logic [31:0] rdData
);
  import rms_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    addr = 8'h00;
    wrData = 32'h0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [`RMS_AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
  endtask
  // Callers wanting steady rms values time this on a zero-crossing mark
  task automatic rd(input logic [`RMS_AW-1:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    addr <= ~a;
    #1;
    d = rdData;
  endtask
  // Gain and offset live in host memory, never in the block
  function automatic logic [31:0] mav_correct(input logic [31:0] raw,
      input logic [15:0] gain, input logic [31:0] ofs);
    return 32'((64'(raw) * 64'(gain)) >> 12) - ofs;
  endfunction
endmodule // rms_host_model

// ===== test/tb.sv
// Purpose: self-checking bench of the rms and mean-absolute block
// Assumes: 250 MHz clock, sample pulses spaced 202 cycles
// Notes: zero samples make rms depend on offsets alone, so values are exact
`timescale 1ns/10ps
`include "rms_params.svh"
module tb;
  import rms_pkg::*;
  logic clock;
  logic rst;
  rms_sample_s sample;
  logic normalPowerMode;
  logic [`RMS_AW-1:0] addr;
  logic [31:0] wrData;
  logic wrStrobe;
  logic rdStrobe;
  logic [31:0] rdData;
  logic [31:0] d0;
  logic [31:0] d1;
  int err_count;
  int cmp_count;
  ////////////////////////////////////////////////////////////////////////////
  rms_measure rms_measure_inst (.clock(clock), .rst(rst), .sample(sample),
    .normalPowerMode(normalPowerMode), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
  rms_host_model rms_host_model_inst (.clock(clock), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rms_host_model_inst.rd(a, d);
    check(d, exp);
  endtask
  // Nonzero and zero-top-bits tests packed into one bit, so one compare covers both
  task automatic rdLive(input logic [7:0] a, input int topBits, output logic [31:0] d);
    rms_host_model_inst.rd(a, d);
    check({31'h0, d != 32'h0 && (d >> (32 - topBits)) == 32'h0}, 32'h1);
  endtask
  // Spacing of 202 cycles, just above the 197 cycles the shared root engine needs
  task automatic pulse(input logic [23:0] a, input logic [23:0] b, input logic [23:0] n);
    @(posedge clock);
    sample.ch[0] <= a;
    sample.ch[1] <= b;
    sample.ch[3] <= n;
    sample.valid <= 1'b1;
    @(posedge clock);
    sample.valid <= 1'b0;
    repeat (200) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset();
    for (int a = 0; a <= 8'h38; a += 4) rdChk(8'(a), 32'h0);
    rdChk(8'hfc, 32'h0);
  endtask
  task automatic testOffset();
    rms_host_model_inst.wr(8'h28, 32'h2);
    rms_host_model_inst.wr(8'h2c, 32'h800000);
    rms_host_model_inst.wr(8'h30, 32'h7fffff);
    rms_host_model_inst.wr(8'h34, 32'h8);
    rdChk(8'h2c, 32'h0f800000);
    rdChk(8'h30, 32'h007fffff);
    pulse(24'h0, 24'h0, 24'h0);
    rdChk(8'h00, 32'h10);
    rdChk(8'h04, 32'h0);
    rdChk(8'h08, 32'h7fff);
    rdChk(8'h0c, 32'h20);
    rdChk(8'h10, 32'h0);
    rms_host_model_inst.wr(8'h00, 32'hffffffff);
    rms_host_model_inst.wr(8'h1c, 32'hffffffff);
    rdChk(8'h00, 32'h10);
    rdChk(8'h1c, 32'h0);
  endtask
  task automatic testSumSel();
    rms_host_model_inst.wr(8'h34, 32'h0);
    rms_host_model_inst.wr(8'h38, 32'h5);
    rdChk(8'h38, 32'h5);
    pulse(24'h001000, 24'hfff000, 24'h100000);
    rdChk(8'h0c, 32'h0);
    rdLive(8'h00, 8, d0);
    rms_host_model_inst.wr(8'h38, 32'h1);
    pulse(24'h001000, 24'hfff000, 24'h100000);
    rdLive(8'h0c, 8, d0);
  endtask
  task automatic testPower();
    logic [31:0] d2;
    @(posedge clock);
    normalPowerMode <= 1'b0;
    rms_host_model_inst.rd(8'h00, d0);
    for (int i = 0; i < 4; i++) pulse(i[0] ? 24'hc00000 : 24'h400000, 24'h0, 24'h0);
    rdChk(8'h00, d0);
    rdLive(8'h1c, 12, d1);
    @(posedge clock);
    normalPowerMode <= 1'b1;
    pulse(24'h400000, 24'h0, 24'h0);
    rms_host_model_inst.rd(8'h1c, d2);
    check({31'h0, d2 != d1}, 32'h1);
    check(rms_host_model_inst.mav_correct(d2, 16'h1000, 32'h0), d2);
    rms_host_model_inst.rd(8'h00, d2);
    check({31'h0, d2 != d0 && d2[31:24] == 8'h00}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    sample = '0;
    normalPowerMode = 1'b1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    testReset();
    testOffset();
    testSumSel();
    testPower();
    finish_test();
  end
  // About 1700 cycles are needed; the margin covers a stuck engine
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    finish_test();
  end
endmodule // tb
